// file: rtl/spb_pkg.sv
/*
  Constants for the sector protection block: unit map, serial opcodes,
  register offsets, field positions and timing.
  Assumes a 100 MHz core clock and a 32-bit APB register bus.
*/
// Notes on behaviour
// - One non-volatile persistent bit per unit
// - Persistent bits program singly, erase together
// - Erase runs internally without host supervision
// - Program and erase take timed intervals; reads answer at once
// - Busy progress visible in status register
// - Array reads refused during persistent programming
// - Erase takes no address; no single erase
// - Persistent bit readable by dedicated command
// - Persistent bits start erased to one
// - One volatile dynamic bit per unit
// - Dynamic bit matters only if persistent one
// - Dynamic write sets zero or one
// - Lock bit zero freezes all persistent bits
// - Locked program or erase fails, nothing changes
// - Persistent mode: lock one after reset
// - Persistent mode: no command sets lock
// - Password mode: lock zero after reset
// - Password mode: only good unlock sets lock
// - Either bit zero blocks program and erase
// - Software reset leaves lock bit unchanged
// - Wrong password sets both errors, lock stays
package spb_pkg;
	localparam int N_UNITS = 542;
	localparam int UNIT_W = 10;
	localparam logic [9:0] TOP_BASE = 10'h1FE;
	localparam logic [7:0] TOP_BLOCK_PAIR = 8'hFF;
	localparam logic [7:0] OP_PPB_READ = 8'hE2;
	localparam logic [7:0] OP_PPB_PROG = 8'hE3;
	localparam logic [7:0] OP_PPB_ERASE = 8'hE4;
	localparam logic [7:0] OP_DYB_READ = 8'hE0;
	localparam logic [7:0] OP_DYB_WRITE = 8'hE1;
	localparam logic [7:0] OP_CLEAR_LOCK = 8'hA6;
	localparam logic [7:0] OP_PWD_UNLOCK = 8'hE9;
	localparam logic [6:0] BITS_OP = 7'h08;
	localparam logic [6:0] BITS_ADDR = 7'h28;
	localparam logic [6:0] BITS_DATA = 7'h30;
	localparam logic [6:0] BITS_PWD = 7'h48;
	localparam logic [7:0] DYB_SET = 8'hFF;
	localparam logic [7:0] DYB_CLR = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_UNIT_SEL = 8'h08;
	localparam logic [7:0] REG_UNIT_STATE = 8'h0C;
	localparam int CTRL_CLR_ERR = 0;
	localparam int CTRL_SOFT_RST = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_PERR = 1;
	localparam int ST_PROTERR = 2;
	localparam int ST_LOCK = 3;
	localparam int ST_PWDMODE = 4;
	localparam int ST_ERASING = 5;
	localparam int ST_READY = 6;
	localparam int US_PPB = 0;
	localparam int US_DYB = 1;
	localparam int US_PROT = 2;
	localparam logic [1:0] INIT_DONE = 2'h3;
	localparam longint CLK_PERIOD_NS = 10;
	localparam longint PROG_TIME_NS = 200000;
	localparam longint ERASE_TIME_NS = 45000000;
	localparam longint PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {SPB_INIT, SPB_IDLE, SPB_PROG, SPB_ERASE} spb_state_e;
endpackage : spb_pkg

// file: rtl/spb_protect.sv
/*
  Sector protection block: persistent and dynamic bits per unit, the
  lock bit, a serial command port and an APB register window.
  Assumes the serial clock comes from the host in another clock domain,
  the mode strap is stable around reset, and the array controller
  asks about protection over the array_* ports on core_clk.
*/
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module spb_protect #(
	parameter int PROG_CYCLES = int'(spb_pkg::PROG_CYCLES),
	parameter int ERASE_CYCLES = int'(spb_pkg::ERASE_CYCLES)
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial command link from the host
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Mode strap and hidden password
	input wire logic password_mode_pin,
	input wire logic [63:0] stored_password,
	// Array controller side
	input wire logic [31:0] array_addr,
	output logic array_protected,
	output logic array_read_refused,
	output logic busy
);
	// Protection bits; persistent ones start erased, as shipped
	logic [spb_pkg::N_UNITS-1:0] persistent_prot_bit = '1;
	logic [spb_pkg::N_UNITS-1:0] dynamic_prot_bit;
	logic persistent_bits_lock, password_mode;
	// Error flags
	logic program_error_flag, protection_error_flag;
	// Sequencer
	spb_pkg::spb_state_e state;
	logic [1:0] init_cnt;
	logic [31:0] timer;
	logic [9:0] target_unit;
	// Synchronisers, first stage read only by second
	logic [2:0] sclk_sync, csn_sync;
	logic [1:0] si_sync, mode_sync;
	// Frame capture
	logic [63:0] shreg;
	logic [6:0] bitcnt;
	logic [7:0] op, data;
	logic [31:0] addr;
	// Register window
	logic [9:0] unit_sel;
	// Map a byte address onto a unit index plus byte-zero check
	function automatic logic [10:0] spb_map(input logic [31:0] a);
		logic [9:0] u;
		logic ok;
		u = 10'h000;
		ok = 1'b0;
		if (a[24:17] == spb_pkg::TOP_BLOCK_PAIR) begin
			u = spb_pkg::TOP_BASE + {5'h00, a[16:12]};
			ok = (a[11:0] == 12'h000);
		end else begin
			u = {1'b0, a[24:16]};
			ok = (a[15:0] == 16'h0000);
		end
		if (a[31:25] != 7'h00) begin
			ok = 1'b0;
		end
		return {ok, u};
	endfunction : spb_map
	// Link edges and the unit addressed by a frame or by the array side
	logic sclk_rise, frame_end, frame_active, si_s;
	logic [10:0] cmd_map, arr_map;
	logic [9:0] cmd_unit;
	logic cmd_addr_ok;
	// Actions decoded from a finished frame, and register writes
	logic go, do_prog, do_erase, do_dyb, do_clr_lock, pwd_ok, fail;
	logic apb_wr, ctrl_wr;
	assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
	assign frame_end = csn_sync[1] & ~csn_sync[2];
	assign frame_active = ~csn_sync[1];
	assign si_s = si_sync[1];
	assign cmd_map = spb_map(addr);
	assign cmd_unit = cmd_map[9:0];
	assign cmd_addr_ok = cmd_map[10];
	assign arr_map = spb_map(array_addr);
	// Decode a finished frame; nothing starts while busy or initialising
	always_comb begin
		go = ce & frame_end & (state == spb_pkg::SPB_IDLE);
		do_prog = 1'b0;
		do_erase = 1'b0;
		do_dyb = 1'b0;
		do_clr_lock = 1'b0;
		pwd_ok = 1'b0;
		fail = 1'b0;
		if (go) begin
			unique case (op)
				spb_pkg::OP_PPB_PROG: begin
					if (bitcnt == spb_pkg::BITS_ADDR && cmd_addr_ok) begin
						do_prog = persistent_bits_lock;
						fail = ~persistent_bits_lock;
					end
				end
				spb_pkg::OP_PPB_ERASE: begin
					// No address taken, all bits go together
					if (bitcnt == spb_pkg::BITS_OP) begin
						do_erase = persistent_bits_lock;
						fail = ~persistent_bits_lock;
					end
				end
				spb_pkg::OP_DYB_WRITE: begin
					do_dyb = (bitcnt == spb_pkg::BITS_DATA) && cmd_addr_ok;
				end
				spb_pkg::OP_CLEAR_LOCK: begin
					do_clr_lock = (bitcnt == spb_pkg::BITS_OP);
				end
				spb_pkg::OP_PWD_UNLOCK: begin
					// Persistent mode has no way to set the lock again
					if (bitcnt == spb_pkg::BITS_PWD && password_mode) begin
						pwd_ok = (shreg == stored_password);
						fail = (shreg != stored_password);
					end
				end
				default: begin
					// Reads and unknown opcodes change no state here
				end
			endcase
		end
	end
	// Two-flop synchronisers plus one edge-history stage
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sclk_sync <= 3'h0;
			csn_sync <= 3'h7;
			si_sync <= 2'h0;
			mode_sync <= 2'h0;
		end else if (ce) begin
			sclk_sync <= {sclk_sync[1:0], sclk};
			csn_sync <= {csn_sync[1:0], cs_n};
			si_sync <= {si_sync[0], si};
			mode_sync <= {mode_sync[0], password_mode_pin};
		end
	end
	// Shift in opcode, address, data and password MSB first
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			shreg <= 64'h0000000000000000;
			bitcnt <= 7'h00;
			op <= 8'h00;
			addr <= 32'h00000000;
			data <= 8'h00;
		end else if (ce) begin
			if (!frame_active) begin
				bitcnt <= 7'h00;
			end else if (sclk_rise) begin
				shreg <= {shreg[62:0], si_s};
				// Saturate so an overlong frame stays invalid
				if (bitcnt != 7'h7F) begin
					bitcnt <= bitcnt + 7'h01;
				end
				if (bitcnt == spb_pkg::BITS_OP - 7'h01) begin
					op <= {shreg[6:0], si_s};
				end
				if (bitcnt == spb_pkg::BITS_ADDR - 7'h01) begin
					addr <= {shreg[30:0], si_s};
				end
				if (bitcnt == spb_pkg::BITS_DATA - 7'h01) begin
					data <= {shreg[6:0], si_s};
				end
			end
		end
	end
	// Read answer: the unit bit repeated on every data clock
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else if (ce) begin
			// Any byte address in the unit answers; no byte-zero check on reads
			if (frame_active && bitcnt >= spb_pkg::BITS_ADDR
				&& (op == spb_pkg::OP_PPB_READ || op == spb_pkg::OP_DYB_READ)) begin
				so_oe <= 1'b1;
				so <= (op == spb_pkg::OP_PPB_READ) ? persistent_prot_bit[cmd_unit]
					: dynamic_prot_bit[cmd_unit];
			end else begin
				so <= 1'b0;
				so_oe <= 1'b0;
			end
		end
	end
	// Sequencer: init after reset, then timed program and erase
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= spb_pkg::SPB_INIT;
			init_cnt <= 2'h0;
			timer <= 32'h00000000;
			target_unit <= 10'h000;
		end else if (ce) begin
			unique case (state)
				spb_pkg::SPB_INIT: begin
					// Wait for the strap to pass its synchroniser
					init_cnt <= init_cnt + 2'h1;
					if (init_cnt == spb_pkg::INIT_DONE) begin
						state <= spb_pkg::SPB_IDLE;
					end
				end
				spb_pkg::SPB_IDLE: begin
					if (do_prog) begin
						state <= spb_pkg::SPB_PROG;
						timer <= 32'(PROG_CYCLES - 1);
						target_unit <= cmd_unit;
					end else if (do_erase) begin
						// Preprogram and verify are folded into this interval
						state <= spb_pkg::SPB_ERASE;
						timer <= 32'(ERASE_CYCLES - 1);
					end
				end
				spb_pkg::SPB_PROG, spb_pkg::SPB_ERASE: begin
					if (timer == 32'h00000000) begin
						state <= spb_pkg::SPB_IDLE;
					end else begin
						timer <= timer - 32'h00000001;
					end
				end
			endcase
		end
	end
	// Persistent bits survive every reset, so they carry no reset term
	always_ff @(posedge core_clk) begin
		if (ce && timer == 32'h00000000) begin
			if (state == spb_pkg::SPB_PROG) begin
				persistent_prot_bit[target_unit] <= 1'b0;
			end else if (state == spb_pkg::SPB_ERASE) begin
				persistent_prot_bit <= '1;
			end
		end
	end
	assign apb_wr = ce & psel & penable & pwrite;
	assign ctrl_wr = apb_wr && paddr[7:0] == spb_pkg::REG_CTRL && paddr[31:8] == 24'h000000;
	// Dynamic bits: unprotected after any reset, written one at a time
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dynamic_prot_bit <= '1;
		end else if (ce) begin
			if (ctrl_wr && pwdata[spb_pkg::CTRL_SOFT_RST]) begin
				dynamic_prot_bit <= '1;
			end else if (do_dyb) begin
				if (data == spb_pkg::DYB_SET) begin
					dynamic_prot_bit[cmd_unit] <= 1'b1;
				end else if (data == spb_pkg::DYB_CLR) begin
					dynamic_prot_bit[cmd_unit] <= 1'b0;
				end
			end
		end
	end
	// Lock bit: value chosen by mode at end of init; soft reset ignored
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			persistent_bits_lock <= 1'b0;
			password_mode <= 1'b0;
		end else if (ce) begin
			if (state == spb_pkg::SPB_INIT) begin
				if (init_cnt == spb_pkg::INIT_DONE) begin
					password_mode <= mode_sync[1];
					// Persistent mode opens, password mode stays shut
					persistent_bits_lock <= ~mode_sync[1];
				end
			end else if (pwd_ok) begin
				persistent_bits_lock <= 1'b1;
			end else if (do_clr_lock) begin
				persistent_bits_lock <= 1'b0;
			end
		end
	end
	// Error flags: a new failure wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			program_error_flag <= 1'b0;
			protection_error_flag <= 1'b0;
		end else if (ce) begin
			if (fail) begin
				program_error_flag <= 1'b1;
				protection_error_flag <= 1'b1;
			end else if (ctrl_wr && (pwdata[spb_pkg::CTRL_CLR_ERR]
				|| pwdata[spb_pkg::CTRL_SOFT_RST])) begin
				program_error_flag <= 1'b0;
				protection_error_flag <= 1'b0;
			end
		end
	end
	// Array side answers, registered one cycle behind the address
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			array_protected <= 1'b1;
			array_read_refused <= 1'b1;
			busy <= 1'b1;
		end else if (ce) begin
			// Either bit at zero protects the unit
			array_protected <= ~(persistent_prot_bit[arr_map[9:0]]
				& dynamic_prot_bit[arr_map[9:0]]);
			array_read_refused <= (state == spb_pkg::SPB_PROG) || (state == spb_pkg::SPB_INIT);
			busy <= (state != spb_pkg::SPB_IDLE);
		end
	end
	// APB: data captured in the setup cycle, zero-wait access phase
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (ce && psel && !penable) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			if (paddr[31:8] != 24'h000000) begin
				pslverr <= 1'b1;
			end else begin
				unique case (paddr[7:0])
					spb_pkg::REG_CTRL: begin
						prdata <= 32'h00000000;
					end
					spb_pkg::REG_STATUS: begin
						prdata[spb_pkg::ST_BUSY] <= (state != spb_pkg::SPB_IDLE);
						prdata[spb_pkg::ST_PERR] <= program_error_flag;
						prdata[spb_pkg::ST_PROTERR] <= protection_error_flag;
						prdata[spb_pkg::ST_LOCK] <= persistent_bits_lock;
						prdata[spb_pkg::ST_PWDMODE] <= password_mode;
						prdata[spb_pkg::ST_ERASING] <= (state == spb_pkg::SPB_ERASE);
						prdata[spb_pkg::ST_READY] <= (state != spb_pkg::SPB_INIT);
					end
					spb_pkg::REG_UNIT_SEL: begin
						prdata[9:0] <= unit_sel;
					end
					spb_pkg::REG_UNIT_STATE: begin
						prdata[spb_pkg::US_PPB] <= persistent_prot_bit[unit_sel];
						prdata[spb_pkg::US_DYB] <= dynamic_prot_bit[unit_sel];
						prdata[spb_pkg::US_PROT] <= ~(persistent_prot_bit[unit_sel]
							& dynamic_prot_bit[unit_sel]);
					end
					default: begin
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end
	// Unit selector for the state window; out-of-range reads unit 0
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			unit_sel <= 10'h000;
		end else if (apb_wr && paddr == {24'h000000, spb_pkg::REG_UNIT_SEL}) begin
			if (pwdata[9:0] < 10'(spb_pkg::N_UNITS)) begin
				unit_sel <= pwdata[9:0];
			end else begin
				unit_sel <= 10'h000;
			end
		end
	end
	// Freezing the clock enable also stalls the bus
	assign pready = ce;
endmodule : spb_protect
`default_nettype wire

// file: testbench/spb_host_model.sv
/* Serial host that frames commands into the protection block.
   Assumes one caller at a time; the link clock is its own. */
`timescale 1ns/1ps
`default_nettype none
module spb_host_model (
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	// Link clock; sclk only moves inside frames
	logic lclk;
	initial begin
		lclk = 1'b0;
		forever #31.25 lclk = ~lclk;
	end
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// n bits out MSB first, then r read clocks; last read bit kept
	task automatic send(input logic [71:0] d, input int n, input int r, output logic rb);
		int i;
		rb = 1'bx;
		@(posedge lclk) cs_n <= 1'b0;
		for (i = n - 1; i >= -r; i--) begin
			@(posedge lclk);
			sclk <= 1'b0;
			// Past the data the line toggles, never holds
			si <= (i >= 0) ? d[i] : ~si;
			@(posedge lclk);
			sclk <= 1'b1;
			if (i < 0) rb = so_oe ? so : 1'bx;
		end
		@(posedge lclk);
		sclk <= 1'b0;
		si <= ~si;
		@(posedge lclk) cs_n <= 1'b1;
	endtask : send
endmodule : spb_host_model
`default_nettype wire

// file: testbench/spb_protect_sva.sv
/* Port checker for the sector protection block.
   Assumes a bind in the bench top that hands on both cycle counts. */
`timescale 1ns/1ps
`default_nettype none
module spb_protect_sva #(
	parameter int PROG_CYCLES = 20,
	parameter int ERASE_CYCLES = 50
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cs_n,
	input wire logic so_oe,
	input wire logic array_read_refused,
	input wire logic busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Length of the running busy stretch
	int busy_len;
	// Lock seen low in persistent mode since reset
	logic lock_low;
	// Finished read of the status word
	logic st_rd;
	assign st_rd = psel && penable && pready && !pwrite && paddr == 32'h00000004;
	// Busy stretch counter
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busy_len <= 0;
		end else begin
			busy_len <= busy ? busy_len + 1 : 0;
		end
	end
	// Only a hardware reset forgets a cleared lock
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lock_low <= 1'b0;
		end else if (st_rd && !prdata[4] && !prdata[3]) begin
			lock_low <= 1'b1;
		end
	end
	chk_apb_ready: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	chk_unmapped_err: assert property (psel && penable && paddr[31:8] != 24'h000000 |-> pslverr)
		else $error("unmapped access not flagged");
	chk_unmapped_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	chk_refuse_busy: assert property (array_read_refused |-> busy)
		else $error("array reads refused while idle");
	chk_busy_bound: assert property (busy_len <= ERASE_CYCLES + 8)
		else $error("busy too long");
	chk_prog_length: assert property ($fell(busy) |-> busy_len < 8 || busy_len >= PROG_CYCLES - 1)
		else $error("operation ended too soon");
	chk_so_release: assert property (cs_n [*8] |-> !so_oe)
		else $error("so driven outside frame");
	chk_lock_sticky: assert property (st_rd && !prdata[4] && lock_low |-> !prdata[3])
		else $error("lock set again by software");
	cover property ($rose(busy));
	cover property (st_rd && prdata[3]);
	cover property (psel && penable && pslverr);
endmodule : spb_protect_sva
`default_nettype wire

// file: testbench/tb_spb_protect.sv
/* Self-checking bench for the sector protection block.
   Assumes short program and erase counts and a host model on the link. */
`timescale 1ns/1ps
`default_nettype none
module tb_spb_protect;
	localparam int PC = 20;
	localparam int EC = 50;
	localparam logic [31:0] A_CT = 32'(spb_pkg::REG_CTRL);
	localparam logic [31:0] A_ST = 32'(spb_pkg::REG_STATUS);
	localparam logic [31:0] A_US = 32'(spb_pkg::REG_UNIT_SEL);
	logic core_clk, rstn, ce, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, array_addr, rv;
	logic sclk, cs_n, si, so, so_oe, password_mode_pin, rb, last_err;
	logic array_protected, array_read_refused, busy;
	logic [63:0] stored_password;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	spb_protect #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) i_spb_protect (.core_clk(core_clk),
		.rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
		.cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .password_mode_pin(password_mode_pin),
		.stored_password(stored_password), .array_addr(array_addr),
		.array_protected(array_protected), .array_read_refused(array_read_refused), .busy(busy));
	spb_host_model i_spb_host_model (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			end_of_test;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One APB transfer; holds the request until pready
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdm(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("register", e, rv & m);
	endtask : rdm
	task automatic ust(input logic [9:0] u, input logic [2:0] e);
		apb(1'b1, A_US, {22'h0, u});
		rdm(32'(spb_pkg::REG_UNIT_STATE), 32'h7, {29'h0, e});
	endtask : ust
	// Frame, then wait out the operation
	task automatic cmd(input logic [71:0] d, input int n);
		i_spb_host_model.send(d, n, 0, rb);
		repeat (8) @(posedge core_clk);
		while (busy === 1'b1) @(posedge core_clk);
	endtask : cmd
	task automatic hw_reset(input logic pm);
		password_mode_pin <= pm;
		rstn <= 1'b0;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (10) @(posedge core_clk);
	endtask : hw_reset
	task automatic t_reset;
		rdm(A_ST, 32'h5F, 32'h48);
		ust(10'h000, 3'b011);
		rdm(32'h10, 32'hFFFFFFFF, 32'h0);
		chk("pslverr", 32'h1, {31'h0, last_err});
		// A valid unit first, so that the out-of-range write must move it
		apb(1'b1, A_US, 32'h00000005);
		apb(1'b1, A_US, 32'h0000021E);
		rdm(A_US, 32'h3FF, 32'h0);
	endtask : t_reset
	task automatic t_dyb;
		cmd({spb_pkg::OP_DYB_WRITE, 32'h00030000, spb_pkg::DYB_CLR}, 48);
		ust(10'd3, 3'b101);
		ust(10'd4, 3'b011);
		i_spb_host_model.send({spb_pkg::OP_DYB_READ, 32'h00030000}, 40, 8, rb);
		chk("dyb read", 32'h0, {31'h0, rb});
		@(posedge core_clk);
		array_addr <= 32'h00035000;
		repeat (3) @(posedge core_clk);
		chk("array_protected", 32'h1, {31'h0, array_protected});
		// Clock enable low: the array answer must not follow a new address
		ce <= 1'b0;
		array_addr <= 32'h00045000;
		repeat (3) @(posedge core_clk);
		chk("frozen", 32'h1, {31'h0, array_protected});
		ce <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("array_protected", 32'h0, {31'h0, array_protected});
		array_addr <= 32'h00035000;
		cmd({spb_pkg::OP_DYB_WRITE, 32'h00030000, spb_pkg::DYB_SET}, 48);
		ust(10'd3, 3'b011);
		chk("array_protected", 32'h0, {31'h0, array_protected});
	endtask : t_dyb
	task automatic t_prog;
		i_spb_host_model.send({spb_pkg::OP_PPB_PROG, 32'h00050000}, 40, 0, rb);
		repeat (8) @(posedge core_clk);
		chk("busy", 32'h1, {31'h0, busy});
		chk("refused", 32'h1, {31'h0, array_read_refused});
		cmd(72'h0, 0);
		ust(10'd5, 3'b110);
		i_spb_host_model.send({spb_pkg::OP_PPB_READ, 32'h00050000}, 40, 8, rb);
		chk("ppb read", 32'h0, {31'h0, rb});
		cmd({spb_pkg::OP_PPB_PROG, 32'h01FE1000}, 40);
		ust(10'd511, 3'b110);
		ust(10'd510, 3'b011);
		cmd({spb_pkg::OP_PPB_PROG, 32'h00060100}, 40);
		ust(10'd6, 3'b011);
	endtask : t_prog
	task automatic t_erase;
		i_spb_host_model.send({64'h0, spb_pkg::OP_PPB_ERASE}, 8, 0, rb);
		repeat (8) @(posedge core_clk);
		rdm(A_ST, 32'h21, 32'h21);
		cmd(72'h0, 0);
		ust(10'd5, 3'b011);
		ust(10'd511, 3'b011);
		i_spb_host_model.send({spb_pkg::OP_PPB_READ, 32'h00050000}, 40, 8, rb);
		chk("ppb read", 32'h1, {31'h0, rb});
	endtask : t_erase
	task automatic t_lock;
		cmd({spb_pkg::OP_PPB_PROG, 32'h00070000}, 40);
		cmd({64'h0, spb_pkg::OP_CLEAR_LOCK}, 8);
		rdm(A_ST, 32'h08, 32'h0);
		cmd({64'h0, spb_pkg::OP_PPB_ERASE}, 8);
		rdm(A_ST, 32'h0E, 32'h06);
		ust(10'd7, 3'b110);
		cmd({spb_pkg::OP_PPB_PROG, 32'h00080000}, 40);
		ust(10'd8, 3'b011);
		cmd({spb_pkg::OP_PWD_UNLOCK, stored_password}, 72);
		rdm(A_ST, 32'h08, 32'h0);
		cmd({spb_pkg::OP_DYB_WRITE, 32'h00090000, spb_pkg::DYB_CLR}, 48);
		apb(1'b1, A_CT, 32'h2);
		ust(10'd9, 3'b011);
		rdm(A_ST, 32'h0E, 32'h0);
		hw_reset(1'b0);
		rdm(A_ST, 32'h18, 32'h08);
	endtask : t_lock
	task automatic t_pwd;
		hw_reset(1'b1);
		rdm(A_ST, 32'h18, 32'h10);
		ust(10'd7, 3'b110);
		cmd({spb_pkg::OP_PWD_UNLOCK, ~stored_password}, 72);
		rdm(A_ST, 32'h0E, 32'h06);
		apb(1'b1, A_CT, 32'h1);
		cmd({spb_pkg::OP_PWD_UNLOCK, stored_password}, 72);
		rdm(A_ST, 32'h0E, 32'h08);
		cmd({64'h0, spb_pkg::OP_PPB_ERASE}, 8);
		ust(10'd7, 3'b011);
	endtask : t_pwd
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		array_addr = 32'h0;
		password_mode_pin = 1'b0;
		stored_password = 64'h0123456789ABCDEF;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (10) @(posedge core_clk);
		t_reset;
		t_dyb;
		t_prog;
		t_erase;
		t_lock;
		t_pwd;
		end_of_test;
	end
endmodule : tb_spb_protect
bind spb_protect spb_protect_sva #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES))
	i_spb_protect_sva (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cs_n(cs_n), .so_oe(so_oe), .array_read_refused(array_read_refused), .busy(busy));
`default_nettype wire
